// ---- rtl/mcu_bus_pkg.sv ----
// constants, carriers and decode helpers for the module bus decoder
package mcu_bus_pkg;
    // ======================================================
    // clocking and timing
    localparam int          CLK_HZ       = 10_000_000;
    localparam int          BAUD         = 1200;
    localparam int          BAUD_DIV_CYC = CLK_HZ / BAUD;
    localparam int          STROBE_CYC   = 2;
    localparam logic [7:0]  RST_PULSE_CYC = 8'h40;
    // ======================================================
    // address map
    localparam logic [15:0] ROM_LAST   = 16'h3fff;
    localparam logic [15:0] RAM_BASE   = 16'h4000;
    localparam logic [15:0] RAM_LAST   = 16'hbfff;
    localparam logic [15:0] PROG_START = 16'h4000;
    localparam logic [15:0] BLK_SIZE   = 16'h1000;
    localparam logic [2:0]  RAM_BLKS   = 3'h7;
    // ======================================================
    // boot codes
    localparam logic [7:0]  CMD_RELOAD = 8'h55;
    localparam logic [7:0]  RPT_PASS   = 8'h50;
    localparam logic [7:0]  RPT_FAIL   = 8'h46;
    localparam logic [7:0]  NAME0      = 8'h42;
    localparam logic [7:0]  NAME1      = 8'h54;
    localparam logic [7:0]  PROBE_KEY  = 8'ha5;
    localparam logic [2:0]  GREET_LAST = 3'h6;
    localparam logic [1:0]  PAT_LAST   = 2'h3;

    typedef struct packed {
        logic rom_n;
        logic ram_n;
        logic select_c_n;
        logic select_d_n;
        logic select_e_n;
        logic select_f_n;
    } sel_s;

    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  data;
    } bus_req_s;

    localparam sel_s SEL_NONE = 6'h3f;

    // one-hot low enable for a full address
    function automatic sel_s decode(input logic [15:0] a);
        sel_s s;
        s = SEL_NONE;
        if (a <= ROM_LAST) begin
            s.rom_n = 1'b0;
        end else if (a <= RAM_LAST) begin
            s.ram_n = 1'b0;
        end else if (a[13:12] == 2'h0) begin
            s.select_c_n = 1'b0;
        end else if (a[13:12] == 2'h1) begin
            s.select_d_n = 1'b0;
        end else if (a[13:12] == 2'h2) begin
            s.select_e_n = 1'b0;
        end else begin
            s.select_f_n = 1'b0;
        end
        return s;
    endfunction

    function automatic logic [7:0] test_pattern(input logic [1:0] k);
        logic [7:0] p;
        p = 8'h55;
        if (k == 2'h1) p = 8'haa;
        else if (k == 2'h2) p = 8'h00;
        else if (k == 2'h3) p = 8'hff;
        return p;
    endfunction
endpackage

// ---- rtl/mcu_bus_decode.sv ----
// external bus engine, address decoder, serial link and boot sequencer
// ======================================================
`timescale 1ns/1ns
module mcu_bus_decode
    import mcu_bus_pkg::*;
#(
    parameter int BAUD_DIV = BAUD_DIV_CYC,
    parameter logic [7:0] REVISION = 8'h01, // arbitrary value
    parameter logic [15:0] TEST_LAST = RAM_LAST
) (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_button_n,
    input  wire logic [7:0]  i_ad_in,
    output logic      [7:0]  o_ad_out,
    output logic             o_ad_oe,
    output logic      [7:0]  o_addr_hi,
    output logic      [7:0]  o_latched_lo,
    output logic             o_addr_latch_pulse,
    output logic             o_store_strobe_n,
    output logic             o_read_strobe_n,
    output sel_s             o_sel,
    output logic      [3:0]  o_connector_low_locator_bits,
    input  wire logic [7:0]  i_connector_byte_lanes,
    output logic      [7:0]  o_connector_byte_lanes,
    output logic             o_connector_byte_lanes_oe,
    input  wire logic [7:0]  i_general_port_drive,
    output logic      [7:0]  o_general_port_pins,
    input  wire logic [7:0]  i_general_port_pins,
    output logic      [7:0]  o_general_port_read,
    input  wire logic        i_serial_receive_line,
    output logic             o_serial_transmit_line,
    output logic             o_sys_reset_n,
    output logic             o_run,
    output logic      [15:0] o_run_addr,
    output logic      [15:0] o_ram_top,
    output logic             o_test_fail
);
    typedef enum {B_IDLE, B_ADDR, B_LATCH, B_STROBE, B_END} bus_e;
    typedef enum {S_PROBE_W, S_PROBE_R, S_WAIT, S_GREET, S_TEST_W, S_TEST_R,
                  S_REPORT, S_CMD, S_LEN, S_LOAD, S_STORE, S_RUN} boot_e;

    // ======================================================
    // supervisor: power-on and button reset pulse
    logic [7:0] hold_ff, nxt_hold;
    logic       btn_ff, nxt_btn, hold;
    logic [7:0] gp_out_ff, gp_in_ff;

    always_comb begin
        nxt_btn  = i_button_n;
        nxt_hold = hold_ff - 8'h01;
        if (btn_ff && !i_button_n) nxt_hold = RST_PULSE_CYC;
        else if (hold_ff == 8'h00) nxt_hold = 8'h00;
    end
    assign hold = (hold_ff != 8'h00);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hold_ff       <= RST_PULSE_CYC;
            btn_ff        <= 1'b1;
            o_sys_reset_n <= 1'b0;
            gp_out_ff     <= 8'h00;
            gp_in_ff      <= 8'h00;
        end else begin
            hold_ff       <= nxt_hold;
            btn_ff        <= nxt_btn;
            o_sys_reset_n <= (nxt_hold == 8'h00);
            gp_out_ff     <= i_general_port_drive;
            gp_in_ff      <= i_general_port_pins;
        end
    end
    assign o_general_port_pins = gp_out_ff;
    assign o_general_port_read = gp_in_ff;

    // ======================================================
    // external bus cycle engine
    bus_e       bst_ff, nxt_bst;
    bus_req_s   req, cur_ff, nxt_cur;
    logic       breq;
    logic [7:0] ad_ff, nxt_ad, hi_ff, nxt_hi, lo_ff, nxt_lo;
    logic [7:0] lane_ff, nxt_lane, rd_ff, nxt_rd;
    logic       adoe_ff, nxt_adoe, ale_ff, nxt_ale, ws_ff, nxt_ws, rs_ff, nxt_rs;
    logic       lnoe_ff, nxt_lnoe;
    logic [1:0] scnt_ff, nxt_scnt;
    sel_s       sel_ff, nxt_sel;
    logic       exp_win, bdone;

    assign exp_win = (cur_ff.addr > RAM_LAST);
    assign bdone   = (bst_ff == B_END);

    always_comb begin
        nxt_bst  = bst_ff;
        nxt_cur  = cur_ff;
        nxt_ad   = ad_ff;
        nxt_hi   = hi_ff;
        nxt_lo   = lo_ff;
        nxt_lane = lane_ff;
        nxt_rd   = rd_ff;
        nxt_adoe = adoe_ff;
        nxt_ale  = 1'b0;
        nxt_ws   = ws_ff;
        nxt_rs   = rs_ff;
        nxt_lnoe = lnoe_ff;
        nxt_scnt = scnt_ff;
        nxt_sel  = decode({hi_ff, lo_ff});
        case (bst_ff)
            B_IDLE: begin
                if (breq && !hold) begin
                    nxt_cur  = req;
                    nxt_hi   = req.addr[15:8];
                    nxt_ad   = req.addr[7:0];
                    nxt_adoe = 1'b1;
                    nxt_ale  = 1'b1;
                    nxt_bst  = B_ADDR;
                end
            end
            B_ADDR: begin
                nxt_lo  = ad_ff;
                nxt_bst = B_LATCH;
            end
            B_LATCH: begin
                nxt_ad   = cur_ff.data;
                nxt_adoe = cur_ff.wr;
                nxt_lane = cur_ff.data;
                nxt_lnoe = cur_ff.wr && exp_win;
                nxt_ws   = !cur_ff.wr;
                nxt_rs   = cur_ff.wr;
                nxt_scnt = 2'(STROBE_CYC - 1);
                nxt_bst  = B_STROBE;
            end
            B_STROBE: begin
                nxt_scnt = scnt_ff - 2'h1;
                if (scnt_ff == 2'h0) begin
                    nxt_rd  = exp_win ? i_connector_byte_lanes : i_ad_in;
                    nxt_ws  = 1'b1;
                    nxt_rs  = 1'b1;
                    nxt_bst = B_END;
                end
            end
            default: begin
                nxt_adoe = 1'b0;
                nxt_lnoe = 1'b0;
                nxt_bst  = B_IDLE;
            end
        endcase
        if (hold) begin
            nxt_bst  = B_IDLE;
            nxt_adoe = 1'b0;
            nxt_lnoe = 1'b0;
            nxt_ws   = 1'b1;
            nxt_rs   = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bst_ff  <= B_IDLE;
            cur_ff  <= '0;
            ad_ff   <= 8'h00;
            hi_ff   <= 8'h00;
            lo_ff   <= 8'h00;
            lane_ff <= 8'h00;
            rd_ff   <= 8'h00;
            adoe_ff <= 1'b0;
            ale_ff  <= 1'b0;
            ws_ff   <= 1'b1;
            rs_ff   <= 1'b1;
            lnoe_ff <= 1'b0;
            scnt_ff <= 2'h0;
            sel_ff  <= SEL_NONE;
        end else begin
            bst_ff  <= nxt_bst;
            cur_ff  <= nxt_cur;
            ad_ff   <= nxt_ad;
            hi_ff   <= nxt_hi;
            lo_ff   <= nxt_lo;
            lane_ff <= nxt_lane;
            rd_ff   <= nxt_rd;
            adoe_ff <= nxt_adoe;
            ale_ff  <= nxt_ale;
            ws_ff   <= nxt_ws;
            rs_ff   <= nxt_rs;
            lnoe_ff <= nxt_lnoe;
            scnt_ff <= nxt_scnt;
            sel_ff  <= nxt_sel;
        end
    end
    assign o_ad_out                     = ad_ff;
    assign o_ad_oe                      = adoe_ff;
    assign o_addr_hi                    = hi_ff;
    assign o_latched_lo                 = lo_ff;
    assign o_addr_latch_pulse           = ale_ff;
    assign o_store_strobe_n             = ws_ff;
    assign o_read_strobe_n              = rs_ff;
    assign o_sel                        = sel_ff;
    assign o_connector_low_locator_bits = lo_ff[3:0];
    assign o_connector_byte_lanes       = lane_ff;
    assign o_connector_byte_lanes_oe    = lnoe_ff;

    // ======================================================
    // serial link, 8 data bits, one stop bit
    logic [15:0] tdiv_ff, nxt_tdiv, rdiv_ff, nxt_rdiv;
    logic [3:0]  tbits_ff, nxt_tbits, rbits_ff, nxt_rbits;
    logic [9:0]  tsh_ff, nxt_tsh;
    logic [7:0]  rsh_ff, nxt_rsh;
    logic        rvld_ff, nxt_rvld, tgo, tidle;
    logic [7:0]  tbyte;

    assign tidle = (tbits_ff == 4'h0);

    always_comb begin
        nxt_tdiv  = tdiv_ff - 16'h1;
        nxt_tbits = tbits_ff;
        nxt_tsh   = tsh_ff;
        nxt_rdiv  = rdiv_ff - 16'h1;
        nxt_rbits = rbits_ff;
        nxt_rsh   = rsh_ff;
        nxt_rvld  = 1'b0;
        if (tidle) begin
            nxt_tdiv = 16'h0;
            if (tgo) begin
                nxt_tsh   = {1'b1, tbyte, 1'b0};
                nxt_tbits = 4'ha;
                nxt_tdiv  = 16'(BAUD_DIV - 1);
            end
        end else if (tdiv_ff == 16'h0) begin
            nxt_tsh   = {1'b1, tsh_ff[9:1]};
            nxt_tbits = tbits_ff - 4'h1;
            nxt_tdiv  = 16'(BAUD_DIV - 1);
        end
        if (rbits_ff == 4'h0) begin
            nxt_rdiv = 16'(BAUD_DIV / 2);
            if (!i_serial_receive_line) nxt_rbits = 4'ha;
        end else if (rdiv_ff == 16'h0) begin
            nxt_rdiv  = 16'(BAUD_DIV - 1);
            nxt_rbits = rbits_ff - 4'h1;
            if (rbits_ff == 4'ha && i_serial_receive_line) nxt_rbits = 4'h0;
            else if (rbits_ff == 4'h1) nxt_rvld = i_serial_receive_line;
            else if (rbits_ff != 4'ha) nxt_rsh = {i_serial_receive_line, rsh_ff[7:1]};
        end
        if (hold) begin
            nxt_tbits = 4'h0;
            nxt_tsh   = 10'h3ff;
            nxt_rbits = 4'h0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tdiv_ff  <= 16'h0;
            tbits_ff <= 4'h0;
            tsh_ff   <= 10'h3ff;
            rdiv_ff  <= 16'h0;
            rbits_ff <= 4'h0;
            rsh_ff   <= 8'h00;
            rvld_ff  <= 1'b0;
        end else begin
            tdiv_ff  <= nxt_tdiv;
            tbits_ff <= nxt_tbits;
            tsh_ff   <= nxt_tsh;
            rdiv_ff  <= nxt_rdiv;
            rbits_ff <= nxt_rbits;
            rsh_ff   <= nxt_rsh;
            rvld_ff  <= nxt_rvld;
        end
    end
    assign o_serial_transmit_line = tsh_ff[0];

    // ======================================================
    // boot sequencer
    boot_e       st_ff, nxt_st;
    logic [15:0] ptr_ff, nxt_ptr, top_ff, nxt_top, len_ff, nxt_len;
    logic [2:0]  idx_ff, nxt_idx;
    logic [1:0]  pat_ff, nxt_pat;
    logic [7:0]  dat_ff, nxt_dat;
    logic        bad_ff, nxt_bad, fail_ff, nxt_fail;

    always_comb begin
        nxt_st   = st_ff;
        nxt_ptr  = ptr_ff;
        nxt_top  = top_ff;
        nxt_len  = len_ff;
        nxt_idx  = idx_ff;
        nxt_pat  = pat_ff;
        nxt_dat  = dat_ff;
        nxt_bad  = bad_ff;
        nxt_fail = fail_ff;
        breq     = 1'b0;
        req      = '{wr: 1'b0, addr: ptr_ff, data: dat_ff};
        tgo      = 1'b0;
        tbyte    = RPT_PASS;
        case (st_ff)
            S_PROBE_W, S_PROBE_R: begin
                breq     = 1'b1;
                req.wr   = (st_ff == S_PROBE_W);
                req.data = PROBE_KEY ^ {5'h0, idx_ff};
                if (bdone && st_ff == S_PROBE_W) nxt_st = S_PROBE_R;
                if (bdone && st_ff == S_PROBE_R) begin
                    nxt_st = S_WAIT;
                    if (rd_ff == req.data) begin
                        nxt_top = ptr_ff + BLK_SIZE - 16'h1;
                        nxt_ptr = ptr_ff + BLK_SIZE;
                        nxt_idx = idx_ff + 3'h1;
                        if (idx_ff != RAM_BLKS) nxt_st = S_PROBE_W;
                    end
                end
                if (nxt_st == S_WAIT) nxt_idx = 3'h0;
            end
            S_WAIT: if (rvld_ff) nxt_st = S_GREET;
            S_GREET: begin
                tgo = 1'b1;
                if (idx_ff == 3'h0) tbyte = NAME0;
                else if (idx_ff == 3'h1) tbyte = NAME1;
                else if (idx_ff == 3'h2) tbyte = REVISION;
                else if (idx_ff == 3'h3) tbyte = RAM_BASE[15:8];
                else if (idx_ff == 3'h4) tbyte = RAM_BASE[7:0];
                else if (idx_ff == 3'h5) tbyte = top_ff[15:8];
                else tbyte = top_ff[7:0];
                if (tidle) begin
                    nxt_idx = idx_ff + 3'h1;
                    if (idx_ff == GREET_LAST) begin
                        nxt_st  = S_TEST_W;
                        nxt_ptr = RAM_BASE;
                        nxt_pat = 2'h0;
                    end
                end
            end
            S_TEST_W, S_TEST_R: begin
                breq     = 1'b1;
                req.wr   = (st_ff == S_TEST_W);
                req.data = test_pattern(pat_ff);
                if (bdone) begin
                    nxt_ptr = ptr_ff + 16'h1;
                    if (st_ff == S_TEST_R && rd_ff != req.data) nxt_bad = 1'b1;
                    if (ptr_ff == top_ff || ptr_ff == TEST_LAST) begin
                        nxt_ptr = RAM_BASE;
                        nxt_st  = (st_ff == S_TEST_W) ? S_TEST_R : S_REPORT;
                    end
                end
            end
            S_REPORT: begin
                tgo   = 1'b1;
                tbyte = bad_ff ? RPT_FAIL : RPT_PASS;
                if (tidle) begin
                    nxt_fail = fail_ff | bad_ff;
                    nxt_bad  = 1'b0;
                    nxt_pat  = pat_ff + 2'h1;
                    nxt_st   = (pat_ff == PAT_LAST) ? S_CMD : S_TEST_W;
                end
            end
            S_LEN: begin
                if (rvld_ff) begin
                    nxt_len = {len_ff[7:0], rsh_ff};
                    nxt_idx = idx_ff + 3'h1;
                    if (idx_ff == 3'h1) begin
                        nxt_ptr = PROG_START;
                        nxt_st  = (nxt_len == 16'h0) ? S_RUN : S_LOAD;
                    end
                end
            end
            S_LOAD: begin
                if (rvld_ff) begin
                    nxt_dat = rsh_ff;
                    nxt_st  = S_STORE;
                end
            end
            S_STORE: begin
                breq   = 1'b1;
                req.wr = 1'b1;
                if (bdone) begin
                    nxt_ptr = ptr_ff + 16'h1;
                    nxt_len = len_ff - 16'h1;
                    nxt_st  = (len_ff == 16'h1) ? S_RUN : S_LOAD;
                end
            end
            default: begin
                if (rvld_ff && rsh_ff == CMD_RELOAD) begin
                    nxt_st  = S_LEN;
                    nxt_idx = 3'h0;
                    nxt_len = 16'h0;
                end
            end
        endcase
        if (hold) begin
            nxt_st   = S_PROBE_W;
            nxt_ptr  = RAM_BASE;
            nxt_top  = RAM_BASE;
            nxt_idx  = 3'h0;
            nxt_bad  = 1'b0;
            nxt_fail = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff      <= S_PROBE_W;
            ptr_ff     <= RAM_BASE;
            top_ff     <= RAM_BASE;
            len_ff     <= 16'h0;
            idx_ff     <= 3'h0;
            pat_ff     <= 2'h0;
            dat_ff     <= 8'h00;
            bad_ff     <= 1'b0;
            fail_ff    <= 1'b0;
            o_run      <= 1'b0;
            o_run_addr <= 16'h0;
        end else begin
            st_ff      <= nxt_st;
            ptr_ff     <= nxt_ptr;
            top_ff     <= nxt_top;
            len_ff     <= nxt_len;
            idx_ff     <= nxt_idx;
            pat_ff     <= nxt_pat;
            dat_ff     <= nxt_dat;
            bad_ff     <= nxt_bad;
            fail_ff    <= nxt_fail;
            o_run      <= (nxt_st == S_RUN);
            o_run_addr <= (nxt_st == S_RUN) ? PROG_START : 16'h0;
        end
    end
    assign o_ram_top   = top_ff;
    assign o_test_fail = fail_ff;
endmodule

// ---- dv/mcu_bus_props.sv ----
// assertions on the bus decoder ports
`timescale 1ns/1ns
module mcu_bus_props
    import mcu_bus_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_button_n,
    input wire logic [7:0]  i_general_port_drive,
    input wire logic [7:0]  o_ad_out,
    input wire logic        o_ad_oe,
    input wire logic [7:0]  o_addr_hi,
    input wire logic [7:0]  o_latched_lo,
    input wire logic        o_addr_latch_pulse,
    input wire logic        o_store_strobe_n,
    input wire logic        o_read_strobe_n,
    input wire sel_s        o_sel,
    input wire logic [3:0]  o_connector_low_locator_bits,
    input wire logic [7:0]  o_general_port_pins,
    input wire logic        o_sys_reset_n,
    input wire logic        o_run,
    input wire logic [15:0] o_run_addr
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic        strb;
    logic [15:0] adr;
    assign strb = !o_store_strobe_n || !o_read_strobe_n;
    assign adr  = {o_addr_hi, o_latched_lo};
    // =====
    // bus cycle
    property p_lat; o_addr_latch_pulse |-> ##2 strb && (o_latched_lo == $past(o_ad_out, 2)); endproperty
    a_lat: assert property (p_lat) else $error("low address not latched");
    property p_mux; strb |-> (o_ad_oe == !o_store_strobe_n); endproperty
    a_mux: assert property (p_mux) else $error("shared port direction wrong");
    property p_wstb; $fell(o_store_strobe_n) |=> !o_store_strobe_n ##1 o_store_strobe_n; endproperty
    a_wstb: assert property (p_wstb) else $error("store strobe width");
    property p_rstb; $fell(o_read_strobe_n) |=> !o_read_strobe_n ##1 o_read_strobe_n; endproperty
    a_rstb: assert property (p_rstb) else $error("read strobe width");
    property p_excl; !(!o_store_strobe_n && !o_read_strobe_n); endproperty
    a_excl: assert property (p_excl) else $error("both strobes low");
    // =====
    // decode
    property p_one; strb |-> $onehot(~o_sel); endproperty
    a_one: assert property (p_one) else $error("enables not exclusive");
    property p_rom; (strb && adr <= 16'h3fff) |-> !o_sel.rom_n; endproperty
    a_rom: assert property (p_rom) else $error("rom enable");
    property p_ram; (strb && adr >= 16'h4000 && adr <= 16'hbfff) |-> !o_sel.ram_n; endproperty
    a_ram: assert property (p_ram) else $error("ram enable");
    property p_exp; (strb && adr >= 16'hc000) |-> (o_sel[3:0] == ~(4'h8 >> o_addr_hi[5:4])); endproperty
    a_exp: assert property (p_exp) else $error("expansion select");
    property p_low; o_connector_low_locator_bits == o_latched_lo[3:0]; endproperty
    a_low: assert property (p_low) else $error("connector address bits");
    // =====
    // ports and reset
    property p_gp; ($past(i_rstn) && o_sys_reset_n && $past(o_sys_reset_n)) |->
        o_general_port_pins == $past(i_general_port_drive); endproperty
    a_gp: assert property (p_gp) else $error("general port");
    property p_run; o_run |-> o_run_addr == 16'h4000; endproperty
    a_run: assert property (p_run) else $error("start address");
    property p_btn; $fell(i_button_n) |-> ##[1:4] !o_sys_reset_n; endproperty
    a_btn: assert property (p_btn) else $error("button reset");
endmodule
bind mcu_bus_decode mcu_bus_props props_inst (.i_clk, .i_rstn, .i_button_n, .i_general_port_drive, .o_ad_out,
    .o_ad_oe, .o_addr_hi, .o_latched_lo, .o_addr_latch_pulse, .o_store_strobe_n, .o_read_strobe_n, .o_sel,
    .o_connector_low_locator_bits, .o_general_port_pins, .o_sys_reset_n, .o_run, .o_run_addr);

// ---- dv/mcu_bus_partner.sv ----
// memory and expansion peripheral model on the far side of the bus
`timescale 1ns/1ns
module mcu_bus_partner
    import mcu_bus_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_fault,
    input  wire sel_s       i_sel,
    input  wire logic       i_store_strobe_n,
    input  wire logic       i_read_strobe_n,
    input  wire logic [7:0] i_addr_hi,
    input  wire logic [7:0] i_latched_lo,
    input  wire logic [7:0] i_ad_out,
    input  wire logic [7:0] i_lanes_out,
    output logic      [7:0] o_ad_in,
    output logic      [7:0] o_lanes_in
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  peri [0:15];
    logic [7:0]  noise = 8'h00;
    logic [15:0] adr;
    logic        mem_rd;
    logic        xsel;
    assign adr    = {i_addr_hi, i_latched_lo};
    assign xsel   = !(i_sel.select_c_n && i_sel.select_d_n && i_sel.select_e_n && i_sel.select_f_n);
    assign mem_rd = !i_read_strobe_n && !(i_sel.rom_n && i_sel.ram_n);
    // released lines change every cycle
    always @(posedge i_clk) begin
        noise <= noise + 8'h3b;
    end
    // bad cell at 4005 when asked
    assign o_ad_in    = !mem_rd ? noise : (i_fault && adr == 16'h4005) ? ~mem[adr] : mem[adr];
    assign o_lanes_in = (xsel && !i_read_strobe_n) ? peri[adr[3:0]] : ~noise;
    always @(posedge i_store_strobe_n) begin
        if (!i_sel.ram_n) mem[adr] <= i_ad_out;
        if (xsel) peri[adr[3:0]] <= i_lanes_out;
    end
endmodule

// ---- dv/tb_mcu_bus_decode.sv ----
// testbench for the bus decoder and boot sequencer
`timescale 1ns/1ns
module tb_mcu_bus_decode
    import mcu_bus_pkg::*;
();
    localparam int         DIV = 16;
    localparam logic [7:0] REV = 8'h3e; // arbitrary value
    logic        i_clk = 1'b0, i_rstn = 1'b0, i_button_n = 1'b1, i_serial_receive_line = 1'b1, fault = 1'b0;
    logic [7:0]  i_general_port_drive = 8'h00, i_general_port_pins = 8'h00;
    logic [7:0]  i_ad_in, o_ad_out, o_addr_hi, o_latched_lo, i_connector_byte_lanes, o_connector_byte_lanes;
    logic [7:0]  o_general_port_pins, o_general_port_read;
    logic        o_ad_oe, o_addr_latch_pulse, o_store_strobe_n, o_read_strobe_n, o_connector_byte_lanes_oe;
    logic        o_serial_transmit_line, o_sys_reset_n, o_run, o_test_fail;
    logic [3:0]  o_connector_low_locator_bits;
    logic [15:0] o_run_addr, o_ram_top;
    sel_s        o_sel;
    int          err_count = 0, num_checks = 0, cycles = 0;
    mcu_bus_decode #(.BAUD_DIV(DIV), .REVISION(REV), .TEST_LAST(16'h400f)) mcu_bus_decode_inst (
        .i_clk, .i_rstn, .i_button_n, .i_ad_in, .o_ad_out, .o_ad_oe, .o_addr_hi, .o_latched_lo,
        .o_addr_latch_pulse, .o_store_strobe_n, .o_read_strobe_n, .o_sel, .o_connector_low_locator_bits,
        .i_connector_byte_lanes, .o_connector_byte_lanes, .o_connector_byte_lanes_oe, .i_general_port_drive,
        .o_general_port_pins, .i_general_port_pins, .o_general_port_read, .i_serial_receive_line,
        .o_serial_transmit_line, .o_sys_reset_n, .o_run, .o_run_addr, .o_ram_top, .o_test_fail);
    mcu_bus_partner mcu_bus_partner_inst (.i_clk, .i_fault(fault), .i_sel(o_sel), .i_store_strobe_n(o_store_strobe_n),
        .i_read_strobe_n(o_read_strobe_n), .i_addr_hi(o_addr_hi), .i_latched_lo(o_latched_lo),
        .i_ad_out(o_ad_out), .i_lanes_out(o_connector_byte_lanes), .o_ad_in(i_ad_in),
        .o_lanes_in(i_connector_byte_lanes));
    // =====
    // helpers
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            $display("BAD %0t timeout", $time);
            wrap_up();
        end
    end
    task wrap_up();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h", $time, m, got);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task send_byte(input logic [7:0] b);
        i_serial_receive_line = 1'b0;
        tk(DIV);
        for (int i = 0; i < 8; i++) begin
            i_serial_receive_line = b[i];
            tk(DIV);
        end
        i_serial_receive_line = 1'b1;
        tk(DIV);
    endtask
    task rx_exp(input logic [7:0] e);
        logic [7:0] b;
        int         n;
        n = 0;
        while (o_serial_transmit_line !== 1'b0 && n < 3000) begin
            tk(1);
            n++;
        end
        tk(DIV / 2);
        for (int i = 0; i < 8; i++) begin
            tk(DIV);
            b[i] = o_serial_transmit_line;
        end
        tk(DIV);
        chk(16'(b), 16'(e), "serial byte");
    endtask
    task wait_reset_end(output int n);
        n = 0;
        while (o_sys_reset_n !== 1'b1 && n < 200) begin
            tk(1);
            n++;
        end
    endtask
    // =====
    // scenarios
    task power_on();
        int n;
        tk(2);
        chk(16'(o_sys_reset_n), 16'h0, "reset out");
        chk(16'(o_sel), 16'h003f, "enables idle");
        i_rstn = 1'b1;
        wait_reset_end(n);
        chk(16'(n >= 60 && n <= 66), 16'h1, "reset hold");
    endtask
    task gport();
        i_general_port_drive = 8'h3c;
        i_general_port_pins = 8'hc3;
        tk(2);
        chk(16'(o_general_port_pins), 16'h3c, "port out");
        chk(16'(o_general_port_read), 16'hc3, "port in");
    endtask
    task boot_greet();
        tk(300);
        fork
            send_byte(8'h0d);
        join_none
        rx_exp(NAME0);
        rx_exp(NAME1);
        rx_exp(REV);
        rx_exp(8'h40);
        rx_exp(8'h00);
        rx_exp(8'hbf);
        rx_exp(8'hff);
        chk(o_ram_top, 16'hbfff, "ram top");
    endtask
    task memtest(input logic [7:0] e, input logic f);
        repeat (4) rx_exp(e);
        chk(16'(o_test_fail), 16'(f), "test fail");
        chk(16'(mcu_bus_partner_inst.mem[16'h400f]), 16'hff, "last pattern");
    endtask
    task reload();
        int n;
        send_byte(CMD_RELOAD);
        send_byte(8'h00);
        send_byte(8'h02);
        send_byte(8'h12);
        send_byte(8'h34);
        n = 0;
        while (o_run !== 1'b1 && n < 500) begin
            tk(1);
            n++;
        end
        chk(16'(o_run), 16'h1, "run");
        chk(o_run_addr, 16'h4000, "run address");
        chk(16'(mcu_bus_partner_inst.mem[16'h4000]), 16'h12, "image 0");
        chk(16'(mcu_bus_partner_inst.mem[16'h4001]), 16'h34, "image 1");
        send_byte(CMD_RELOAD);
        chk(16'(o_run), 16'h0, "reload stops run");
        repeat (2) send_byte(8'h00);
        chk(16'(o_run), 16'h1, "empty image");
    endtask
    task button_fault();
        int n;
        fault = 1'b1;
        i_button_n = 1'b0;
        tk(4);
        chk(16'(o_sys_reset_n), 16'h0, "button reset");
        i_button_n = 1'b1;
        wait_reset_end(n);
        chk(16'(o_sys_reset_n), 16'h1, "reset ends");
        boot_greet();
        memtest(RPT_FAIL, 1'b1);
    endtask
    initial begin
        power_on();
        gport();
        boot_greet();
        memtest(RPT_PASS, 1'b0);
        reload();
        button_fault();
        wrap_up();
    end
endmodule
